// File: rlfi_pkg.sv
// shared types and constants for the retry layer frame interface
package rlfi_pkg;
   localparam int WORD_W = 32;
   localparam int SEQ_W  = 7;
   localparam int CH_N   = 3;
   // channel indices, also the lane and delivery type codes
   localparam logic [1:0] CH_DATA = 2'h0;
   localparam logic [1:0] CH_FCT  = 2'h1;
   localparam logic [1:0] CH_BC   = 2'h2;
   localparam logic [SEQ_W-1:0] SEQ_ZERO = 7'h00;
   localparam logic [SEQ_W-1:0] SEQ_STEP = 7'h01;
   localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [7:0] BC_CNT_ZERO = 8'h00;
   localparam logic [7:0] BC_CNT_STEP = 8'h01;

   // control words seen on the receive lane
   typedef enum logic [2:0] {
      CW_NONE = 3'h0,
      CW_SDF  = 3'h1,
      CW_EDF  = 3'h2,
      CW_SBF  = 3'h3,
      CW_EBF  = 3'h4,
      CW_SIF  = 3'h5,
      CW_FCT  = 3'h6,
      CW_OTHR = 3'h7
   } rlfi_ctrl_e;

   // word identification states, one-hot
   typedef enum logic [4:0] {
      ST_NOTHING = 5'h01,
      ST_DATA    = 5'h02,
      ST_BCAST   = 5'h04,
      ST_BCDATA  = 5'h08,
      ST_IDLE    = 5'h10
   } rlfi_state_e;

   // word tag handed up with each received word
   typedef enum logic [1:0] {
      TAG_NONE  = 2'h0,
      TAG_DATA  = 2'h1,
      TAG_BCAST = 2'h2,
      TAG_IDLE  = 2'h3
   } rlfi_tag_e;

   typedef struct packed {
      logic             valid;
      logic             isCtrl;
      rlfi_ctrl_e       code;
      logic [SEQ_W-1:0] seq;
      logic [WORD_W-1:0] data;
   } rlfi_rxword_s;

   typedef struct packed {
      logic              valid;
      logic [1:0]        chan;
      logic [SEQ_W-1:0]  seq;
      logic [WORD_W-1:0] data;
   } rlfi_lanetx_s;

   typedef struct packed {
      logic              valid;
      logic [1:0]        chan;
      logic [WORD_W-1:0] data;
   } rlfi_deliver_s;
endpackage

// File: rlfi_tx_slot.sv
// one retransmit slot: holds an item until the far end acknowledges it
`timescale 1ns/100ps
module rlfi_tx_slot (
   // clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst,
   // from the framing side
   input  wire logic                        req,
   input  wire logic [rlfi_pkg::WORD_W-1:0] itemIn,
   // lane arbitration
   input  wire logic                        grant,
   input  wire logic [rlfi_pkg::SEQ_W-1:0]  seqIn,
   // far end outcome
   input  wire logic                        ack,
   input  wire logic                        nack,
   // state
   output logic                             busy_ff,
   output logic                             pend_ff,
   output logic                             sent_ff,
   output logic [rlfi_pkg::SEQ_W-1:0]       seq_ff,
   output logic [rlfi_pkg::WORD_W-1:0]      item_ff
);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_ff <= 1'b0;
         item_ff <= rlfi_pkg::WORD_ZERO;
      end else if (req && !busy_ff) begin
         busy_ff <= 1'b1;
         item_ff <= itemIn;
      end else if (ack && sent_ff && !pend_ff) begin
         busy_ff <= 1'b0;
      end
   end

   // retransmission keeps the original sequence number
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pend_ff <= 1'b0;
         sent_ff <= 1'b0;
         seq_ff  <= rlfi_pkg::SEQ_ZERO;
      end else if (req && !busy_ff) begin
         pend_ff <= 1'b1;
         sent_ff <= 1'b0;
      end else if (grant) begin
         pend_ff <= 1'b0;
         if (!sent_ff) begin
            seq_ff <= seqIn;
         end
         sent_ff <= 1'b1;
      end else if (nack && sent_ff && busy_ff) begin
         pend_ff <= 1'b1;
      end
   end

   chk_nack_resend: assert property (@(posedge clk_sys) disable iff (rst)
      (nack && sent_ff && busy_ff && !pend_ff && !grant) |=> pend_ff && busy_ff)
      else $error("nacked item not queued for resend");
   chk_ack_frees: assert property (@(posedge clk_sys) disable iff (rst)
      (ack && sent_ff && !pend_ff && busy_ff) |=> !busy_ff)
      else $error("acknowledged item still held");
endmodule

// File: rlfi_seq_check.sv
// receive frame sequence counter and sequence error flag
`timescale 1ns/100ps
module rlfi_seq_check (
   // clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       rst,
   input  wire logic                       flush,
   // numbered words
   input  wire logic                       seqChk,
   input  wire logic                       isIdle,
   input  wire logic [rlfi_pkg::SEQ_W-1:0] seqIn,
   // result: error flag combinational for the same cycle, counter registered
   output logic                            seqErr,
   output logic [rlfi_pkg::SEQ_W-1:0]      cnt_ff
);
   logic [rlfi_pkg::SEQ_W-1:0] expected;

   // 7-bit wrap gives modulo 128
   always_comb begin
      expected = isIdle ? cnt_ff : cnt_ff + rlfi_pkg::SEQ_STEP;
      seqErr   = seqChk && (seqIn != expected);
   end

   always_ff @(posedge clk_sys) begin
      if (rst || flush) begin
         cnt_ff <= rlfi_pkg::SEQ_ZERO;
      end else if (seqChk && !seqErr && !isIdle) begin
         cnt_ff <= expected;
      end
   end

   chk_seq_flag: assert property (@(posedge clk_sys) disable iff (rst)
      (seqChk && !isIdle && seqIn == cnt_ff + rlfi_pkg::SEQ_STEP) |-> !seqErr)
      else $error("in-order number flagged");
   chk_idle_match: assert property (@(posedge clk_sys) disable iff (rst)
      (seqChk && isIdle && seqIn != cnt_ff) |-> seqErr)
      else $error("idle number mismatch missed");
endmodule

// File: rlfi_retry_if.sv
// retry layer service boundary: transmit slots, word identification, delivery
`timescale 1ns/100ps
module rlfi_retry_if (
   // clock and reset
   input  wire logic                                  clk_sys,
   input  wire logic                                  rst,
   // transmit requests from framing: data, fct, broadcast
   input  wire logic [rlfi_pkg::CH_N-1:0]             txReq,
   input  wire logic [rlfi_pkg::CH_N-1:0][rlfi_pkg::WORD_W-1:0] txItem,
   output logic [rlfi_pkg::CH_N-1:0]                  txRdy_ff,
   // lane transmit
   input  wire logic                                  laneTxReady,
   output rlfi_pkg::rlfi_lanetx_s                     laneTx_ff,
   // far end outcome per channel
   input  wire logic [rlfi_pkg::CH_N-1:0]             farAck,
   input  wire logic [rlfi_pkg::CH_N-1:0]             farNack,
   // lane receive
   input  wire rlfi_pkg::rlfi_rxword_s                laneRx,
   input  wire logic                                  rxError,
   input  wire logic                                  crcError,
   input  wire logic                                  remoteFlush,
   // delivery to framing
   output rlfi_pkg::rlfi_deliver_s                    deliver_ff,
   output rlfi_pkg::rlfi_tag_e                        rxTag_ff,
   output logic                                       rxTagValid_ff,
   output logic                                       seqError_ff,
   output logic [7:0]                                 bcWordCnt_ff
);
   logic [rlfi_pkg::CH_N-1:0]                         busy;
   logic [rlfi_pkg::CH_N-1:0]                         pend;
   logic [rlfi_pkg::CH_N-1:0]                         sent;
   logic [rlfi_pkg::CH_N-1:0][rlfi_pkg::SEQ_W-1:0]    slotSeq;
   logic [rlfi_pkg::CH_N-1:0][rlfi_pkg::WORD_W-1:0]   slotItem;
   logic [rlfi_pkg::CH_N-1:0]                         grant;
   logic [rlfi_pkg::CH_N-1:0]                         accept;
   logic [rlfi_pkg::SEQ_W-1:0]                        txSeq_ff;
   logic [1:0]                                        grantCh;

   // ---------------- transmit ----------------
   assign accept = txReq & txRdy_ff;

   genvar gi;
   generate
      for (gi = 0; gi < rlfi_pkg::CH_N; gi++) begin : g_slot
         rlfi_tx_slot u_slot (
            .clk_sys (clk_sys),
            .rst     (rst),
            .req     (accept[gi]),
            .itemIn  (txItem[gi]),
            .grant   (grant[gi]),
            .seqIn   (txSeq_ff),
            .ack     (farAck[gi]),
            .nack    (farNack[gi]),
            .busy_ff (busy[gi]),
            .pend_ff (pend[gi]),
            .sent_ff (sent[gi]),
            .seq_ff  (slotSeq[gi]),
            .item_ff (slotItem[gi])
         );
      end
   endgenerate

   // broadcast and fct go out ahead of data, broadcast ahead of fct, the highest pending one granted as soon as the lane is ready
   always_comb begin
      grant   = '0;
      grantCh = rlfi_pkg::CH_DATA;
      if (laneTxReady) begin
         if (pend[rlfi_pkg::CH_BC]) begin
            grant[rlfi_pkg::CH_BC] = 1'b1;
            grantCh = rlfi_pkg::CH_BC;
         end else if (pend[rlfi_pkg::CH_FCT]) begin
            grant[rlfi_pkg::CH_FCT] = 1'b1;
            grantCh = rlfi_pkg::CH_FCT;
         end else if (pend[rlfi_pkg::CH_DATA]) begin
            grant[rlfi_pkg::CH_DATA] = 1'b1;
            grantCh = rlfi_pkg::CH_DATA;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         laneTx_ff <= '0;
      end else begin
         laneTx_ff.valid <= |grant;
         laneTx_ff.chan  <= grantCh;
         laneTx_ff.data  <= slotItem[grantCh];
         laneTx_ff.seq   <= sent[grantCh] ? slotSeq[grantCh] : txSeq_ff;
      end
   end

   // a fresh number only for first sends; resends reuse theirs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txSeq_ff <= rlfi_pkg::SEQ_ZERO;
      end else if ((|grant) && !sent[grantCh]) begin
         txSeq_ff <= txSeq_ff + rlfi_pkg::SEQ_STEP;
      end
   end

   // ready drops the cycle after a take, and whenever the lane is full
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txRdy_ff <= '0;
      end else begin
         txRdy_ff <= {rlfi_pkg::CH_N{laneTxReady}} & ~busy & ~accept;
      end
   end

   // ---------------- receive ----------------
   rlfi_pkg::rlfi_state_e state_ff;
   rlfi_pkg::rlfi_state_e nxt_state;
   logic                            seqChk;
   logic                            seqErr;
   logic                            isIdleNum;
   logic [rlfi_pkg::SEQ_W-1:0]      rxSeqCnt;
   logic                            isCw;
   logic                            abortRx;
   logic                            seqChkClean;
   logic [rlfi_pkg::WORD_W-1:0]     dataHold_ff;
   logic [rlfi_pkg::WORD_W-1:0]     bcHold_ff;

   assign isCw      = laneRx.valid && laneRx.isCtrl;
   assign isIdleNum = isCw && laneRx.code == rlfi_pkg::CW_SIF;
   assign seqChk    = isCw && (laneRx.code == rlfi_pkg::CW_EDF
                            || laneRx.code == rlfi_pkg::CW_EBF
                            || laneRx.code == rlfi_pkg::CW_FCT
                            || laneRx.code == rlfi_pkg::CW_SIF);
   assign abortRx   = rxError || crcError || seqErr;
   // an errored word must not move the counter, or its resend is refused
   assign seqChkClean = seqChk && !rxError && !crcError;

   rlfi_seq_check u_seq (
      .clk_sys (clk_sys),
      .rst     (rst),
      .flush   (remoteFlush),
      .seqChk  (seqChkClean),
      .isIdle  (isIdleNum),
      .seqIn   (laneRx.seq),
      .seqErr  (seqErr),
      .cnt_ff  (rxSeqCnt)
   );

   always_comb begin
      nxt_state = state_ff;
      if (abortRx) begin
         nxt_state = rlfi_pkg::ST_NOTHING;
      end else if (isCw) begin
         case (state_ff)
            rlfi_pkg::ST_NOTHING, rlfi_pkg::ST_IDLE: begin
               if (laneRx.code == rlfi_pkg::CW_SBF) begin
                  nxt_state = rlfi_pkg::ST_BCAST;
               end else if (laneRx.code == rlfi_pkg::CW_SDF) begin
                  nxt_state = rlfi_pkg::ST_DATA;
               end else if (laneRx.code == rlfi_pkg::CW_SIF) begin
                  nxt_state = rlfi_pkg::ST_IDLE;
               end else if (state_ff == rlfi_pkg::ST_IDLE
                            && laneRx.code != rlfi_pkg::CW_FCT) begin
                  nxt_state = rlfi_pkg::ST_NOTHING;
               end
            end
            rlfi_pkg::ST_DATA: begin
               if (laneRx.code == rlfi_pkg::CW_SBF) begin
                  nxt_state = rlfi_pkg::ST_BCDATA;
               end else if (laneRx.code != rlfi_pkg::CW_FCT) begin
                  nxt_state = rlfi_pkg::ST_NOTHING;
               end
            end
            rlfi_pkg::ST_BCAST: begin
               if (laneRx.code != rlfi_pkg::CW_FCT) begin
                  nxt_state = rlfi_pkg::ST_NOTHING;
               end
            end
            rlfi_pkg::ST_BCDATA: begin
               if (laneRx.code == rlfi_pkg::CW_EBF) begin
                  nxt_state = rlfi_pkg::ST_DATA;
               end else if (laneRx.code != rlfi_pkg::CW_FCT) begin
                  nxt_state = rlfi_pkg::ST_NOTHING;
               end
            end
            default: nxt_state = rlfi_pkg::ST_NOTHING;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || remoteFlush) begin
         state_ff <= rlfi_pkg::ST_NOTHING;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // tag each plain data word by the frame it sits in
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rxTag_ff      <= rlfi_pkg::TAG_NONE;
         rxTagValid_ff <= 1'b0;
      end else begin
         rxTagValid_ff <= laneRx.valid && !laneRx.isCtrl;
         case (state_ff)
            rlfi_pkg::ST_DATA:   rxTag_ff <= rlfi_pkg::TAG_DATA;
            rlfi_pkg::ST_BCAST,
            rlfi_pkg::ST_BCDATA: rxTag_ff <= rlfi_pkg::TAG_BCAST;
            rlfi_pkg::ST_IDLE:   rxTag_ff <= rlfi_pkg::TAG_IDLE;
            default:             rxTag_ff <= rlfi_pkg::TAG_NONE;
         endcase
      end
   end

   localparam logic [7:0] BC_STEP = rlfi_pkg::BC_CNT_STEP;

   // the last word of each data or broadcast frame is held until the closing word proves it good
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dataHold_ff  <= rlfi_pkg::WORD_ZERO;
         bcHold_ff    <= rlfi_pkg::WORD_ZERO;
         bcWordCnt_ff <= rlfi_pkg::BC_CNT_ZERO;
      end else if (laneRx.valid && !laneRx.isCtrl) begin
         if (state_ff == rlfi_pkg::ST_DATA) begin
            dataHold_ff <= laneRx.data;
         end
         if (state_ff == rlfi_pkg::ST_BCAST || state_ff == rlfi_pkg::ST_BCDATA) begin
            bcHold_ff    <= laneRx.data;
            bcWordCnt_ff <= bcWordCnt_ff + BC_STEP;
         end
      end else if (isCw && laneRx.code == rlfi_pkg::CW_SBF) begin
         bcWordCnt_ff <= rlfi_pkg::BC_CNT_ZERO;
      end
   end
   logic goodEnd;
   assign goodEnd = isCw && !abortRx;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         deliver_ff  <= '0;
         seqError_ff <= 1'b0;
      end else begin
         seqError_ff      <= seqErr;
         deliver_ff.valid <= 1'b0;
         if (goodEnd && laneRx.code == rlfi_pkg::CW_EDF
             && state_ff == rlfi_pkg::ST_DATA) begin
            deliver_ff.valid <= 1'b1;
            deliver_ff.chan  <= rlfi_pkg::CH_DATA;
            deliver_ff.data  <= dataHold_ff;
         end else if (goodEnd && laneRx.code == rlfi_pkg::CW_EBF
                      && (state_ff == rlfi_pkg::ST_BCAST
                          || state_ff == rlfi_pkg::ST_BCDATA)) begin
            deliver_ff.valid <= 1'b1;
            deliver_ff.chan  <= rlfi_pkg::CH_BC;
            deliver_ff.data  <= bcHold_ff;
         end else if (goodEnd && laneRx.code == rlfi_pkg::CW_FCT) begin
            deliver_ff.valid <= 1'b1;
            deliver_ff.chan  <= rlfi_pkg::CH_FCT;
            deliver_ff.data  <= laneRx.data;
         end
      end
   end

   // ---------------- checks ----------------
   sequence s_cwIn(rlfi_pkg::rlfi_ctrl_e c);
      laneRx.valid && laneRx.isCtrl && laneRx.code == c && !rxError && !crcError;
   endsequence

   chk_rdy_lane: assert property (@(posedge clk_sys) disable iff (rst)
      (|txRdy_ff) |-> $past(laneTxReady))
      else $error("ready raised while lane was full");
   chk_take_drops: assert property (@(posedge clk_sys) disable iff (rst)
      accept[0] |=> !txRdy_ff[0] ##1 !txRdy_ff[0] || !busy[0])
      else $error("data ready stayed high after a take");
   chk_fct_rdy: assert property (@(posedge clk_sys) disable iff (rst)
      txRdy_ff[1] |-> !busy[1])
      else $error("fct ready while slot held");
   chk_bc_first: assert property (@(posedge clk_sys) disable iff (rst)
      (laneTxReady && pend[2]) |=> laneTx_ff.valid && laneTx_ff.chan == rlfi_pkg::CH_BC)
      else $error("pending broadcast not sent next");
   chk_data_good: assert property (@(posedge clk_sys) disable iff (rst)
      (deliver_ff.valid && deliver_ff.chan == rlfi_pkg::CH_DATA)
         |-> $past(goodEnd) && $past(state_ff) == rlfi_pkg::ST_DATA)
      else $error("data frame delivered without clean end");
   chk_fct_good: assert property (@(posedge clk_sys) disable iff (rst)
      s_cwIn(rlfi_pkg::CW_FCT) ##0 !seqErr |=> deliver_ff.valid
         && deliver_ff.chan == rlfi_pkg::CH_FCT)
      else $error("good fct not delivered");
   chk_bc_seqbad: assert property (@(posedge clk_sys) disable iff (rst)
      seqErr |=> !deliver_ff.valid ##0 seqError_ff)
      else $error("delivery despite sequence error");
   chk_err_nothing: assert property (@(posedge clk_sys) disable iff (rst)
      (rxError || crcError) |=> state_ff == rlfi_pkg::ST_NOTHING)
      else $error("error did not reset identification");
   chk_start_prio: assert property (@(posedge clk_sys) disable iff (rst)
      (state_ff == rlfi_pkg::ST_NOTHING) ##0 s_cwIn(rlfi_pkg::CW_SDF)
         |=> state_ff == rlfi_pkg::ST_DATA)
      else $error("start of data not entered");
   chk_state_onehot: assert property (@(posedge clk_sys) disable iff (rst)
      $onehot(state_ff))
      else $error("identification state not one-hot");
   chk_data_tag: assert property (@(posedge clk_sys) disable iff (rst)
      (laneRx.valid && !laneRx.isCtrl && state_ff == rlfi_pkg::ST_DATA)
         |=> rxTag_ff == rlfi_pkg::TAG_DATA)
      else $error("data word tag wrong");
   chk_err_noadv: assert property (@(posedge clk_sys) disable iff (rst)
      (seqChk && (rxError || crcError) && !remoteFlush) |=> rxSeqCnt == $past(rxSeqCnt))
      else $error("errored word moved the receive counter");
endmodule

// File: rlfi_framer_model.sv
// framing layer model: raises requests on ready and collects deliveries
`timescale 1ns/100ps
module rlfi_framer_model (
   // clock
   input  wire logic                                        clk_sys,
   // retry layer side
   input  wire logic [rlfi_pkg::CH_N-1:0]                   txRdy,
   input  wire rlfi_pkg::rlfi_deliver_s                     deliver,
   output logic [rlfi_pkg::CH_N-1:0]                        txReq,
   output logic [rlfi_pkg::CH_N-1:0][rlfi_pkg::WORD_W-1:0]  txItem
);
   int gotCnt [3];

   initial begin
      txReq = '0;
      txItem = '0;
   end

   // delivered items are counted per channel
   always @(negedge clk_sys) begin
      if (deliver.valid === 1'b1) begin
         gotCnt[deliver.chan]++;
      end
   end

   task automatic send(input int ch, input logic [31:0] item, output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 40 && !ok; i++) begin
         @(negedge clk_sys);
         ok = (txRdy[ch] === 1'b1);
      end
      if (ok) begin
         txReq[ch] = 1'b1;
         txItem[ch] = item;
         @(negedge clk_sys);
         txReq[ch] = 1'b0;
         // released item must not keep looking valid
         txItem[ch] = ~item;
      end
   endtask
endmodule

// File: test_rlfi_retry_if.sv
// self-checking bench for the retry layer frame interface
`timescale 1ns/100ps
module test_rlfi_retry_if;
   logic                    clk_sys     = 1'b0;
   logic                    rst         = 1'b1;
   logic                    laneTxReady = 1'b0;
   logic [2:0]              farAck      = 3'h0;
   logic [2:0]              farNack     = 3'h0;
   rlfi_pkg::rlfi_rxword_s  laneRx      = '0;
   logic                    rxError     = 1'b0;
   logic                    crcError    = 1'b0;
   logic                    remoteFlush = 1'b0;
   logic [2:0]              txReq;
   logic [2:0]              txRdy;
   logic [2:0][31:0]        txItem;
   rlfi_pkg::rlfi_lanetx_s  laneTx;
   rlfi_pkg::rlfi_deliver_s deliver;
   rlfi_pkg::rlfi_tag_e     rxTag;
   logic                    rxTagValid;
   logic                    seqError;
   logic [7:0]              bcCnt;
   logic [6:0]              rxCnt       = 7'h00;
   int                      failCount   = 0;
   int                      checkCount  = 0;

   always #2.5 clk_sys = ~clk_sys;

   rlfi_retry_if dut (.clk_sys(clk_sys), .rst(rst), .txReq(txReq), .txItem(txItem),
      .txRdy_ff(txRdy), .laneTxReady(laneTxReady), .laneTx_ff(laneTx), .farAck(farAck),
      .farNack(farNack), .laneRx(laneRx), .rxError(rxError), .crcError(crcError),
      .remoteFlush(remoteFlush), .deliver_ff(deliver), .rxTag_ff(rxTag),
      .rxTagValid_ff(rxTagValid), .seqError_ff(seqError), .bcWordCnt_ff(bcCnt));
   rlfi_framer_model fl (.clk_sys(clk_sys), .txRdy(txRdy), .deliver(deliver),
      .txReq(txReq), .txItem(txItem));

   task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
      checkCount++;
      if (got !== exp) begin
         failCount++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic waitTx(output int n);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (laneTx.valid !== 1'b1 && n < 20);
   endtask

   task automatic test_tx(input int ch, input logic [31:0] item);
      bit         ok;
      int         n;
      logic [6:0] seq;
      fl.send(ch, item, ok);
      cmp(ok, 1'b1);
      waitTx(n);
      seq = laneTx.seq;
      cmp({n[7:0], laneTx.chan, laneTx.data}, {8'h01, ch[1:0], item});
      cmp(txRdy[ch], 1'b0);
      farNack[ch] = 1'b1;
      @(negedge clk_sys);
      farNack[ch] = 1'b0;
      waitTx(n);
      cmp({n < 20, laneTx.seq, laneTx.data}, {1'b1, seq, item});
      farAck[ch] = 1'b1;
      @(negedge clk_sys);
      farAck[ch] = 1'b0;
      n = 0;
      while (txRdy[ch] !== 1'b1 && n < 10) begin
         @(negedge clk_sys);
         n++;
      end
      cmp(txRdy[ch], 1'b1);
      $display("transmit test on channel %0d done", ch);
   endtask

   // drives one receive word; err bit 0 is crc, bit 1 is receive error
   task automatic rxw(input logic ctl, input rlfi_pkg::rlfi_ctrl_e code,
                      input logic [6:0] seq, input logic [31:0] data, input logic [1:0] err);
      laneRx = {1'b1, ctl, code, seq, data};
      crcError = err[0];
      rxError = err[1];
      @(negedge clk_sys);
   endtask

   task automatic rxIdle(input logic flush);
      laneRx = {1'b0, laneRx.isCtrl, laneRx.code, laneRx.seq, ~laneRx.data};
      crcError = 1'b0;
      rxError = 1'b0;
      remoteFlush = flush;
      @(negedge clk_sys);
      remoteFlush = 1'b0;
      if (flush) begin
         rxCnt = 7'h00;
      end
   endtask

   task automatic test_rx();
      rxw(1'b1, rlfi_pkg::CW_SDF, 7'h00, 32'h0, 2'h0);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'ha5a5_0001, 2'h0);
      cmp({rxTagValid, rxTag}, {1'b1, rlfi_pkg::TAG_DATA});
      rxw(1'b1, rlfi_pkg::CW_EDF, rxCnt + 7'h01, 32'h0, 2'h0);
      cmp(deliver, {1'b1, rlfi_pkg::CH_DATA, 32'ha5a5_0001});
      rxCnt++;
      // enough tokens to wrap the receive counter
      for (int i = 0; i < 130; i++) begin
         rxw(1'b1, rlfi_pkg::CW_FCT, rxCnt + 7'h01, 32'h0, 2'h0);
         rxCnt++;
      end
      cmp({seqError, deliver.valid, deliver.chan}, {2'b01, rlfi_pkg::CH_FCT});
      rxw(1'b1, rlfi_pkg::CW_SBF, 7'h00, 32'h0, 2'h0);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'hbbbb_0001, 2'h0);
      cmp({rxTagValid, rxTag, bcCnt}, {1'b1, rlfi_pkg::TAG_BCAST, 8'h01});
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'hcccc_0002, 2'h0);
      cmp(bcCnt, 8'h02);
      rxw(1'b1, rlfi_pkg::CW_EBF, rxCnt + 7'h01, 32'h0, 2'h0);
      cmp(deliver, {1'b1, rlfi_pkg::CH_BC, 32'hcccc_0002});
      rxCnt++;
      // broadcast nested in a data frame, then the data frame closes
      rxw(1'b1, rlfi_pkg::CW_SDF, 7'h00, 32'h0, 2'h0);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'hdddd_0001, 2'h0);
      rxw(1'b1, rlfi_pkg::CW_SBF, 7'h00, 32'h0, 2'h0);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'heeee_0002, 2'h0);
      cmp({rxTagValid, rxTag, bcCnt}, {1'b1, rlfi_pkg::TAG_BCAST, 8'h01});
      rxw(1'b1, rlfi_pkg::CW_EBF, rxCnt + 7'h01, 32'h0, 2'h0);
      cmp(deliver, {1'b1, rlfi_pkg::CH_BC, 32'heeee_0002});
      rxCnt++;
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'hffff_0003, 2'h0);
      cmp({rxTagValid, rxTag}, {1'b1, rlfi_pkg::TAG_DATA});
      rxw(1'b1, rlfi_pkg::CW_EDF, rxCnt + 7'h01, 32'h0, 2'h0);
      cmp(deliver, {1'b1, rlfi_pkg::CH_DATA, 32'hffff_0003});
      rxCnt++;
      rxIdle(1'b0);
      $display("receive test done");
   endtask

   task automatic test_err();
      rxw(1'b1, rlfi_pkg::CW_SDF, 7'h00, 32'h0, 2'h0);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'h1111_0001, 2'h0);
      rxw(1'b1, rlfi_pkg::CW_EDF, rxCnt + 7'h02, 32'h0, 2'h0);
      cmp({deliver.valid, seqError}, 2'b01);
      rxIdle(1'b1);
      rxw(1'b1, rlfi_pkg::CW_SIF, 7'h00, 32'h0, 2'h0);
      cmp(seqError, 1'b0);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'h5555_0001, 2'h0);
      cmp({rxTagValid, rxTag}, {1'b1, rlfi_pkg::TAG_IDLE});
      rxw(1'b1, rlfi_pkg::CW_SIF, 7'h05, 32'h0, 2'h0);
      cmp(seqError, 1'b1);
      rxIdle(1'b1);
      rxw(1'b1, rlfi_pkg::CW_SDF, 7'h00, 32'h0, 2'h0);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'h2222_0001, 2'h1);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'h2222_0002, 2'h0);
      cmp({rxTagValid, rxTag}, {1'b1, rlfi_pkg::TAG_NONE});
      rxw(1'b1, rlfi_pkg::CW_SDF, 7'h00, 32'h0, 2'h0);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'h3333_0001, 2'h0);
      rxw(1'b1, rlfi_pkg::CW_EDF, 7'h01, 32'h0, 2'h2);
      cmp(deliver.valid, 1'b0);
      // no flush: the resend below must still match the counter
      rxIdle(1'b0);
      rxw(1'b1, rlfi_pkg::CW_SDF, 7'h00, 32'h0, 2'h0);
      rxw(1'b0, rlfi_pkg::CW_NONE, 7'h00, 32'h4444_0001, 2'h0);
      rxw(1'b1, rlfi_pkg::CW_EDF, 7'h01, 32'h0, 2'h0);
      cmp(deliver, {1'b1, rlfi_pkg::CH_DATA, 32'h4444_0001});
      rxIdle(1'b0);
      $display("receive error test done");
   endtask

   initial begin
      repeat (20) @(negedge clk_sys);
      cmp({txRdy, deliver.valid, seqError, bcCnt}, 13'h0000);
      rst = 1'b0;
      repeat (3) @(negedge clk_sys);
      cmp(txRdy, 3'h0);
      laneTxReady = 1'b1;
      repeat (2) @(negedge clk_sys);
      cmp(txRdy, 3'h7);
      $display("reset test done");
      for (int ch = 0; ch < 3; ch++) begin
         test_tx(ch, 32'hc0de_0000 + ch);
      end
      test_rx();
      test_err();
      cmp({fl.gotCnt[0][15:0], fl.gotCnt[1][15:0], fl.gotCnt[2][15:0]},
          {16'h0003, 16'h0082, 16'h0002});
      results();
   end

   // run needs about 215 cycles; this cuts a hang short
   initial begin
      #100000;
      failCount++;
      $display("watchdog expired");
      results();
   end
endmodule
